// ===== i2cs_slave.sv
// two-wire register access slave with input filters and clock crossing
`timescale 1ns/100ps

module i2cs_glitch_filter (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic level_in,
   output logic      level_out
);
   logic [i2cs_pkg::FILT_W-1:0] cnt;

   // output follows only after the input holds a new level long enough
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt       <= '0;
         level_out <= 1'b1;
      end else if (level_in == level_out) begin
         cnt <= '0;
      end else if (cnt == i2cs_pkg::FILT_W'(i2cs_pkg::SPIKE_CYC)) begin
         cnt       <= '0;
         level_out <= level_in;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule : i2cs_glitch_filter

module i2cs_slave (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic       link_clk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic [1:0] port_select_upper_in,
   input  wire logic [1:0] port_select_lower_in,
   output logic            reg_wr_out,
   output logic            reg_rd_out,
   output logic [15:0]     reg_addr_out,
   output logic [7:0]      reg_wdata_out,
   input  wire logic [7:0] reg_rdata_in,
   output logic            update_out
);
   // ---------------- link domain ----------------
   logic                   lrst_s1;
   logic                   lrst;
   logic                   scl_s1;
   logic                   scl_s2;
   logic                   sda_s1;
   logic                   sda_s2;
   logic [1:0]             selu_s1;
   logic [1:0]             selu_s2;
   logic [1:0]             sell_s1;
   logic [1:0]             sell_s2;
   logic                   scl_f;
   logic                   sda_f;
   logic                   scl_d;
   logic                   sda_d;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_det;
   logic                   stop_det;
   logic                   port_on;
   logic [6:0]             own_addr;
   logic [2:0]             addr_low;
   i2cs_pkg::i2cs_state_t  state;
   logic [3:0]             bitcnt;
   logic [7:0]             rx_sh;
   logic [7:0]             tx_sh;
   logic                   rnw;
   logic                   nack;
   logic [1:0]             widx;
   logic                   oe;
   logic                   addr_hit;
   logic                   rd_start;
   logic                   load_tx;
   logic                   wbyte;
   logic [15:0]            ptr;
   i2cs_pkg::i2cs_req_t    req;
   logic                   req_tog;
   logic                   ack_s1;
   logic                   ack_s2;
   logic                   ack_s3;
   logic [7:0]             lrdata;
   // ---------------- system domain ----------------
   logic                   rq_s1;
   logic                   rq_s2;
   logic                   rq_s3;
   logic                   rq_edge;
   logic                   rd_pend;
   logic [7:0]             rdata_hold;
   logic                   ack_tog;

   // reset is carried into the link domain through two flops
   always_ff @(posedge link_clk_in) begin
      lrst_s1 <= srst_in;
      lrst    <= lrst_s1;
   end

   // pins are asynchronous to the link clock
   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         scl_s1  <= 1'b1;
         scl_s2  <= 1'b1;
         sda_s1  <= 1'b1;
         sda_s2  <= 1'b1;
         selu_s1 <= i2cs_pkg::SEL_LOW;
         selu_s2 <= i2cs_pkg::SEL_LOW;
         sell_s1 <= i2cs_pkg::SEL_LOW;
         sell_s2 <= i2cs_pkg::SEL_LOW;
      end else begin
         scl_s1  <= scl_in;
         scl_s2  <= scl_s1;
         sda_s1  <= sda_in;
         sda_s2  <= sda_s1;
         selu_s1 <= port_select_upper_in;
         selu_s2 <= selu_s1;
         sell_s1 <= port_select_lower_in;
         sell_s2 <= sell_s1;
      end
   end

   i2cs_glitch_filter u_scl_filt (
      .clk_in    (link_clk_in),
      .rst_in    (lrst),
      .level_in  (scl_s2),
      .level_out (scl_f)
   );

   i2cs_glitch_filter u_sda_filt (
      .clk_in    (link_clk_in),
      .rst_in    (lrst),
      .level_in  (sda_s2),
      .level_out (sda_f)
   );

   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   // edges are taken on the filtered lines only
   always_comb begin
      scl_rise  = scl_f & ~scl_d;
      scl_fall  = ~scl_f & scl_d;
      start_det = scl_f & scl_d & sda_d & ~sda_f;
      stop_det  = scl_f & scl_d & ~sda_d & sda_f;
   end

   // three-level selects give a value 0..8; 8 hands the pins to the other port
   always_comb begin
      port_on  = !(selu_s2 == i2cs_pkg::SEL_HIGH &&
                   sell_s2 == i2cs_pkg::SEL_HIGH);
      addr_low = 3'({1'b0, selu_s2} * 3'h3 + {1'b0, sell_s2});
      own_addr = {i2cs_pkg::ADDR_UPPER, addr_low};
   end

   // byte-boundary strobes shared by the sequencer and the pointer logic
   always_comb begin
      addr_hit = scl_fall && state == i2cs_pkg::ST_ADDR &&
                 bitcnt == i2cs_pkg::BYTE_BITS &&
                 rx_sh[7:1] == own_addr && port_on;
      rd_start = addr_hit && rx_sh[0];
      load_tx  = scl_fall && ((state == i2cs_pkg::ST_AACK && rnw) ||
                              (state == i2cs_pkg::ST_TACK && !nack));
      wbyte    = scl_fall && state == i2cs_pkg::ST_WRX &&
                 bitcnt == i2cs_pkg::BYTE_BITS;
   end

   // bit sequencer; start with the port on wins over everything but reset and drops any partial byte
   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         state  <= i2cs_pkg::ST_IDLE;
         bitcnt <= '0;
         rx_sh  <= i2cs_pkg::BYTE_ZERO;
         tx_sh  <= i2cs_pkg::BYTE_ZERO;
         rnw    <= 1'b0;
         nack   <= 1'b0;
         widx   <= i2cs_pkg::WIDX_ADDR_HI;
         oe     <= 1'b0;
      end else if (start_det && port_on) begin
         state  <= i2cs_pkg::ST_ADDR;
         bitcnt <= '0;
         oe     <= 1'b0;
      end else if (stop_det || !port_on) begin
         state  <= i2cs_pkg::ST_IDLE;
         bitcnt <= '0;
         oe     <= 1'b0;
      end else if (scl_rise) begin
         case (state)
            i2cs_pkg::ST_ADDR,
            i2cs_pkg::ST_WRX: begin
               rx_sh  <= {rx_sh[6:0], sda_f};
               bitcnt <= bitcnt + 1'b1;
            end
            i2cs_pkg::ST_TX: begin
               bitcnt <= bitcnt + 1'b1;
            end
            i2cs_pkg::ST_TACK: begin
               nack <= sda_f;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         // data is only driven low just after the clock falls; start, stop and port off release it at any time
         case (state)
            i2cs_pkg::ST_ADDR: begin
               if (bitcnt == i2cs_pkg::BYTE_BITS) begin
                  if (addr_hit) begin
                     state <= i2cs_pkg::ST_AACK;
                     rnw   <= rx_sh[0];
                     widx  <= i2cs_pkg::WIDX_ADDR_HI;
                     oe    <= 1'b1;
                  end else begin
                     state <= i2cs_pkg::ST_IDLE;
                  end
               end
            end
            i2cs_pkg::ST_AACK,
            i2cs_pkg::ST_TACK: begin
               bitcnt <= '0;
               if (load_tx) begin
                  state <= i2cs_pkg::ST_TX;
                  tx_sh <= lrdata;
                  oe    <= ~lrdata[7];
               end else if (state == i2cs_pkg::ST_AACK) begin
                  state <= i2cs_pkg::ST_WRX;
                  oe    <= 1'b0;
               end else begin
                  state <= i2cs_pkg::ST_IDLE;
                  oe    <= 1'b0;
               end
            end
            i2cs_pkg::ST_WRX: begin
               if (bitcnt == i2cs_pkg::BYTE_BITS) begin
                  state <= i2cs_pkg::ST_WACK;
                  oe    <= 1'b1;
                  if (widx != i2cs_pkg::WIDX_DATA) begin
                     widx <= widx + 1'b1;
                  end
               end
            end
            i2cs_pkg::ST_WACK: begin
               // the master may stop or restart after this ack
               state  <= i2cs_pkg::ST_WRX;
               bitcnt <= '0;
               oe     <= 1'b0;
            end
            i2cs_pkg::ST_TX: begin
               if (bitcnt == i2cs_pkg::BYTE_BITS) begin
                  state <= i2cs_pkg::ST_TACK;
                  oe    <= 1'b0;
               end else begin
                  tx_sh <= {tx_sh[6:0], 1'b0};
                  oe    <= ~tx_sh[6];
               end
            end
            default: begin
               state <= i2cs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // open drain: only ever pull low, and the clock line is never driven
   always_comb begin
      sda_out    = 1'b0;
      sda_oe_out = oe;
   end

   // held register address and requests toward the register buffer
   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         ptr     <= i2cs_pkg::PTR_RESET;
         req     <= '0;
         req_tog <= 1'b0;
      end else if (wbyte) begin
         case (widx)
            i2cs_pkg::WIDX_ADDR_HI: begin
               ptr[15:8] <= rx_sh;
            end
            i2cs_pkg::WIDX_ADDR_LO: begin
               ptr[7:0] <= rx_sh;
            end
            default: begin
               req     <= '{wr: 1'b1, addr: ptr, data: rx_sh};
               req_tog <= ~req_tog;
               ptr     <= ptr + 16'h0001;
            end
         endcase
      end else if (rd_start) begin
         // fetch ahead so the byte is ready before the first data bit
         req     <= '{wr: 1'b0, addr: ptr, data: i2cs_pkg::BYTE_ZERO};
         req_tog <= ~req_tog;
      end else if (load_tx) begin
         req     <= '{wr: 1'b0, addr: ptr + 16'h0001, data: i2cs_pkg::BYTE_ZERO};
         req_tog <= ~req_tog;
         ptr     <= ptr + 16'h0001;
      end
   end

   // read data returns by toggle handshake; word is stable when toggle lands
   always_ff @(posedge link_clk_in) begin
      if (lrst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
         lrdata <= i2cs_pkg::BYTE_ZERO;
      end else begin
         ack_s1 <= ack_tog;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         if (ack_s2 != ack_s3) begin
            lrdata <= rdata_hold;
         end
      end
   end

   // ---------------- system clock side ----------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rq_s1 <= 1'b0;
         rq_s2 <= 1'b0;
         rq_s3 <= 1'b0;
      end else begin
         rq_s1 <= req_tog;
         rq_s2 <= rq_s1;
         rq_s3 <= rq_s2;
      end
   end

   assign rq_edge = rq_s2 ^ rq_s3;

   // the request word is written on the same link edge as its toggle
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         reg_wr_out    <= 1'b0;
         reg_rd_out    <= 1'b0;
         reg_addr_out  <= i2cs_pkg::PTR_RESET;
         reg_wdata_out <= i2cs_pkg::BYTE_ZERO;
         update_out    <= 1'b0;
      end else begin
         reg_wr_out <= rq_edge & req.wr;
         reg_rd_out <= rq_edge & ~req.wr;
         update_out <= rq_edge & req.wr &
                       req.addr == i2cs_pkg::UPDATE_ADDR &
                       req.data[i2cs_pkg::UPDATE_BIT];
         if (rq_edge) begin
            reg_addr_out  <= req.addr;
            reg_wdata_out <= req.data;
         end
      end
   end

   // read data is taken the cycle after the read strobe
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rd_pend    <= 1'b0;
         rdata_hold <= i2cs_pkg::BYTE_ZERO;
         ack_tog    <= 1'b0;
      end else begin
         rd_pend <= reg_rd_out;
         if (rd_pend) begin
            rdata_hold <= reg_rdata_in;
            ack_tog    <= ~ack_tog;
         end
      end
   end

endmodule : i2cs_slave

// ===== i2cs_pkg.sv
// constants and types for the two-wire register access slave
// What this block does
// - works at 100 kHz and 400 kHz; the master picks the clock rate
// - slave only; never drives the serial clock line
// - register address is two bytes wide
// - data changes only while clock is low; one clock pulse per bit
// - data falling while clock high is a start
// - data rising while clock high is a stop
// - bytes are eight bits, msb first, then an acknowledge slot
// - receiver acknowledges by holding data low in the ninth pulse
// - receiver leaves data high in the ninth pulse to not-acknowledge
// - acknowledge own address only; otherwise stay idle until next start
// - write: first two bytes are register address, high first
// - no limit on the number of data bytes per transfer
// - read: data follows address acknowledge, from the held register address
// - master not-acknowledges last read byte; slave then releases data
// - repeated start acts as start of a new transfer
// - start or stop at any bit; partial bytes are discarded
// - address-only write just loads the held register address
// - combined read: address write, repeated start, then read
// - clock and data inputs reject short glitches
// - any start resets the slave to receive a fresh address
// - slave address is 1011 plus three bits from the port selects
// - port disabled when both port selects are high
// - writing one to update bit 0 of 0x232 makes data active
package i2cs_pkg;

   localparam logic [3:0]  ADDR_UPPER   = 4'hB;
   localparam logic [1:0]  SEL_LOW      = 2'h0;
   localparam logic [1:0]  SEL_OPEN     = 2'h1;
   localparam logic [1:0]  SEL_HIGH     = 2'h2;
   localparam logic [15:0] UPDATE_ADDR  = 16'h0232;
   localparam int          UPDATE_BIT   = 0;
   localparam logic [3:0]  BYTE_BITS    = 4'h8;
   localparam logic [1:0]  WIDX_ADDR_HI = 2'h0;
   localparam logic [1:0]  WIDX_ADDR_LO = 2'h1;
   localparam logic [1:0]  WIDX_DATA    = 2'h2;
   localparam logic [15:0] PTR_RESET    = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;

   // input spike suppression, in ns and in cycles of the sampling clock
   localparam int          CLK_MHZ      = 100;
   localparam int          SPIKE_NS     = 50;
   localparam int          SPIKE_CYC    = (SPIKE_NS * CLK_MHZ + 999) / 1000;
   localparam int          FILT_W       = 4;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_WRX  = 7'h08,
      ST_WACK = 7'h10,
      ST_TX   = 7'h20,
      ST_TACK = 7'h40
   } i2cs_state_t;

   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } i2cs_req_t;

endpackage : i2cs_pkg

// ===== i2cs_slave_sva.sv
// port assertions for the two-wire register slave
`timescale 1ns/100ps
module i2cs_slave_sva (
   input wire logic        clk_in,
   input wire logic        srst_in,
   input wire logic        link_clk_in,
   input wire logic        scl_in,
   input wire logic        sda_oe_out,
   input wire logic [1:0]  port_select_upper_in,
   input wire logic [1:0]  port_select_lower_in,
   input wire logic        reg_wr_out,
   input wire logic        reg_rd_out,
   input wire logic [15:0] reg_addr_out,
   input wire logic [7:0]  reg_wdata_out,
   input wire logic        update_out
);
   a_wr_single: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_wr_out |=> !reg_wr_out && !reg_rd_out) else $error("write pulse too long");
   a_addr_held: assert property (@(posedge clk_in) disable iff (srst_in)
      !reg_wr_out && !reg_rd_out |-> $stable(reg_addr_out) && $stable(reg_wdata_out))
      else $error("address moved between requests");
   a_update_cause: assert property (@(posedge clk_in) disable iff (srst_in)
      update_out |-> reg_wr_out && reg_addr_out == 16'h0232 && reg_wdata_out[0])
      else $error("update without its write");
   a_update_due: assert property (@(posedge clk_in) disable iff (srst_in)
      reg_wr_out && reg_addr_out == 16'h0232 && reg_wdata_out[0] |-> update_out)
      else $error("update missing");
   a_oe_rise_low: assert property (@(posedge link_clk_in) disable iff (srst_in)
      $rose(sda_oe_out) |-> !scl_in) else $error("data driven while clock high");
   a_oe_still_high: assert property (@(posedge link_clk_in) disable iff (srst_in)
      scl_in && $past(scl_in) |-> $stable(sda_oe_out)) else $error("data moved in high");
   a_oe_stands: assert property (@(posedge link_clk_in) disable iff (srst_in)
      $rose(sda_oe_out) |=> sda_oe_out [*8]) else $error("low level too short");
   a_port_off: assert property (@(posedge link_clk_in) disable iff (srst_in)
      port_select_upper_in == 2'h2 && port_select_lower_in == 2'h2 |-> !sda_oe_out)
      else $error("disabled port drove data");
endmodule : i2cs_slave_sva

// ===== i2cs_master_model.sv
// behavioural bus master driving clock and open-drain data
`timescale 1ns/100ps
module i2cs_master_model (
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // quarter bit in ns; whole system periods keep edges on falling system edges, < 400 kHz
   int q = 630;
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic start_cond();
      sda_low_out = 1'b0;
      #(q) scl_out = 1'b1;
      #(q) sda_low_out = 1'b1;
      #(q) scl_out = 1'b0;
   endtask : start_cond
   task automatic stop_cond();
      #(q) sda_low_out = 1'b1;
      #(q) scl_out = 1'b1;
      #(q) sda_low_out = 1'b0;
      #(q);
   endtask : stop_cond
   task automatic put_bit(input logic b, output logic s);
      #(q) sda_low_out = !b;
      #(q) scl_out = 1'b1;
      #(q) s = sda_in;
      #(q) scl_out = 1'b0;
   endtask : put_bit
   task automatic xfer(input logic [7:0] d, input int n, input logic last,
                       output logic [7:0] got, output logic ack);
      got = 8'h00;
      ack = 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         put_bit(d[i], got[i]);
      end
      if (n == 8) begin
         put_bit(last, ack);
      end
   endtask : xfer
endmodule : i2cs_master_model

// ===== tb.sv
// self-checking bench for the two-wire register slave
`timescale 1ns/100ps
module tb;
   logic        clk_in = 1'b0;
   logic        link_clk = 1'b0;
   logic        srst_in = 1'b1;
   logic        m_scl, m_low, sda_wire, sda_out, sda_oe, reg_wr, reg_rd, upd, ack;
   logic [1:0]  sel_up = 2'h0;
   logic [1:0]  sel_lo = 2'h0;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, got;
   logic [7:0]  rdata = 8'h00;
   logic [23:0] e;
   logic [6:0]  sa;
   logic [23:0] exp_q[$];
   logic [7:0]  regs[int];
   logic [7:0]  mdl[int];
   int          failures = 0;
   int          n_compared = 0;
   int          ptr;

   always #5 clk_in = ~clk_in;
   // offset by a fraction so link edges never meet system or master edges
   initial begin
      #2.5;
      forever #6 link_clk = ~link_clk;
   end
   // released data floats high through the bus pull-up
   assign sda_wire = !(m_low || (sda_oe && !sda_out));
   i2cs_slave u_dut (.clk_in(clk_in), .srst_in(srst_in), .link_clk_in(link_clk),
      .scl_in(m_scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
      .port_select_upper_in(sel_up), .port_select_lower_in(sel_lo),
      .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
      .reg_wdata_out(reg_wdata), .reg_rdata_in(rdata), .update_out(upd));
   i2cs_master_model u_master (.sda_in(sda_wire), .scl_out(m_scl), .sda_low_out(m_low));

   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   function automatic logic [7:0] dflt(input logic [15:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction : dflt

   // register file on the far side; unwritten places read a fixed pattern
   always @(posedge clk_in) begin
      if (reg_rd) begin
         rdata <= regs.exists(reg_addr) ? regs[reg_addr] : dflt(reg_addr);
      end
      if (reg_wr) begin
         regs[reg_addr] = reg_wdata;
         if (exp_q.size() == 0) begin
            check("stray write", 24'h1, 24'h0);
         end else begin
            e = exp_q.pop_front();
            check("write addr", reg_addr, e[23:8]);
            check("write data", reg_wdata, e[7:0]);
            check("update", upd, e[23:8] == i2cs_pkg::UPDATE_ADDR && e[0]);
         end
      end
   end

   task automatic snd(input logic [7:0] d, input logic exp_ack, input string nm);
      u_master.xfer(d, 8, 1'b1, got, ack);
      check(nm, ack, exp_ack);
   endtask : snd
   task automatic open_xfer(input logic rd);
      u_master.start_cond();
      snd({sa, rd}, 1'b0, "address ack");
   endtask : open_xfer
   task automatic set_ptr(input logic [15:0] p);
      open_xfer(1'b0);
      snd(p[15:8], 1'b0, "pointer high ack");
      snd(p[7:0], 1'b0, "pointer low ack");
      ptr = p;
   endtask : set_ptr
   task automatic wr_data(input logic [7:0] d);
      exp_q.push_back({ptr[15:0], d});
      mdl[ptr] = d;
      snd(d, 1'b0, "data ack");
      ptr = (ptr + 1) & 16'hFFFF;
   endtask : wr_data
   task automatic rd_data(input logic last);
      u_master.xfer(8'hFF, 8, last, got, ack);
      check("read data", got, mdl.exists(ptr) ? mdl[ptr] : dflt(ptr[15:0]));
      ptr = (ptr + 1) & 16'hFFFF;
   endtask : rd_data

   initial begin
      void'($urandom(91077));
      sel_up = 2'($urandom % 3);
      sel_lo = 2'($urandom % ((sel_up == 2'h2) ? 2 : 3));
      sa = {i2cs_pkg::ADDR_UPPER, 3'(sel_up * 3 + sel_lo)};
      repeat (6) @(negedge clk_in);
      srst_in = 1'b0;
      repeat (30) @(negedge clk_in);
      set_ptr(16'h0230);
      // a 30 ns clock spike in the low phase must not clock in an extra bit
      #(300) u_master.scl_out = 1'b1;
      #(30) u_master.scl_out = 1'b0;
      wr_data(8'($urandom));
      wr_data(8'($urandom));
      wr_data(8'($urandom) | 8'h01);
      u_master.stop_cond();
      u_master.q = 2500;
      open_xfer(1'b1);
      rd_data(1'b1);
      u_master.stop_cond();
      u_master.q = 630;
      set_ptr(16'h0230);
      open_xfer(1'b1);
      rd_data(1'b0);
      rd_data(1'b0);
      rd_data(1'b1);
      u_master.stop_cond();
      u_master.start_cond();
      snd({sa ^ 7'h04, 1'b0}, 1'b1, "foreign nack");
      snd(8'h00, 1'b1, "idle after foreign");
      u_master.stop_cond();
      // a stop in mid byte must leave no write behind
      set_ptr(16'h0300);
      u_master.xfer(8'hA5, 4, 1'b1, got, ack);
      u_master.stop_cond();
      open_xfer(1'b1);
      rd_data(1'b1);
      u_master.stop_cond();
      @(negedge clk_in);
      sel_up = 2'h2;
      sel_lo = 2'h2;
      u_master.start_cond();
      snd({sa, 1'b0}, 1'b1, "port off nack");
      u_master.stop_cond();
      repeat (50) @(negedge clk_in);
      check("writes left", 24'(exp_q.size()), 24'h0);
      close_out();
   end

   initial begin
      repeat (95000) @(posedge clk_in);
      failures++;
      close_out();
   end
endmodule : tb

bind i2cs_slave i2cs_slave_sva u_sva (.clk_in(clk_in), .srst_in(srst_in),
   .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
   .port_select_upper_in(port_select_upper_in), .port_select_lower_in(port_select_lower_in),
   .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_addr_out(reg_addr_out),
   .reg_wdata_out(reg_wdata_out), .update_out(update_out));
